/* pfbo_regs.vh */
`ifndef PFBO_REGS_VH
`define PFBO_REGS_VH
// bus op codes on the user command port
`define PFBO_OP_READ      3'h0
`define PFBO_OP_WRITE     3'h1
`define PFBO_OP_PROTECT   3'h2
`define PFBO_OP_UNPROT    3'h3
`define PFBO_OP_PVERIFY   3'h4
`define PFBO_OP_UVERIFY   3'h5
`define PFBO_OP_SIGREAD   3'h6
// timing, clock 125 MHz
`define PFBO_CLK_MHZ      125
`define PFBO_T_SETUP_NS   64
`define PFBO_SETUP_CYC    ((`PFBO_T_SETUP_NS * `PFBO_CLK_MHZ + 999) / 1000)
`define PFBO_T_STROBE_NS  80
`define PFBO_STROBE_CYC   ((`PFBO_T_STROBE_NS * `PFBO_CLK_MHZ + 999) / 1000)
`define PFBO_T_PROT_US    100
`define PFBO_PROT_CYC     (`PFBO_T_PROT_US * `PFBO_CLK_MHZ)
`define PFBO_T_UNPROT_MS  10
`define PFBO_UNPROT_CYC   (`PFBO_T_UNPROT_MS * 1000 * `PFBO_CLK_MHZ)
// address bit positions and verify codes
`define PFBO_A0           0
`define PFBO_A1           1
`define PFBO_A6           6
`define PFBO_A12          12
`define PFBO_A15          15
`define PFBO_BLK_LSB      12
`define PFBO_PROT_CODE    8'h01
`define PFBO_UNPROT_CODE  8'h00
`endif

/* pfbo_sync.v */
`timescale 1ns/1ps
`default_nettype none
module pfbo_sync
#(
   parameter W = 16
)
(
   input  wire         clk_i,
   input  wire         rst_n_i,
   input  wire [W-1:0] d_i,
   output reg  [W-1:0] q_o
);
   reg [W-1:0] s1;
   reg [W-1:0] s2;
   reg [W-1:0] s3;
   always @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         s1  <= {W{1'b0}};
         s2  <= {W{1'b0}};
         s3  <= {W{1'b0}};
         q_o <= {W{1'b0}};
      end
      else
      begin
         s1 <= d_i;
         s2 <= s1;
         s3 <= s2;
         // accept only when second and third stages agree
         if (s2 == s3)
            q_o <= s3;
      end
   end
endmodule
`default_nettype wire

/* pfbo_host.v */
`timescale 1ns/1ps
`default_nettype none
`include "pfbo_regs.vh"
module pfbo_host
#(
   parameter PROT_CYC   = `PFBO_PROT_CYC,
   parameter UNPROT_CYC = `PFBO_UNPROT_CYC
)
(
   input  wire        clk_i,
   input  wire        rst_n_i,
   input  wire        req_i,
   input  wire [2:0]  op_i,
   input  wire [17:0] addr_i,
   input  wire [15:0] wdata_i,
   input  wire        word_mode_i,
   input  wire        temp_unprot_i,
   output reg         busy_o,
   output reg         done_o,
   output reg  [15:0] rdata_o,
   output reg         prot_ok_o,
   output reg         all_prot_o,
   output reg         chip_sel_n_o,
   output reg         chip_sel_hv_o,
   output reg         out_en_n_o,
   output reg         out_en_hv_o,
   output reg         wr_en_n_o,
   output reg         hard_rst_n_o,
   output reg         hard_rst_hv_o,
   output reg         hv_sense_pin_o,
   output reg         byte_word_o,
   output reg  [17:0] addr_o,
   input  wire [15:0] dq_i,
   output reg  [15:0] dq_o,
   output reg         dq_oe_o,
   output reg         upper_dq_or_lsb_addr_oe_o
);
   localparam S_IDLE   = 3'h0;
   localparam S_SETUP  = 3'h1;
   localparam S_STROBE = 3'h2;
   localparam S_HOLD   = 3'h3;
   localparam S_DONE   = 3'h4;
   localparam [23:0] SETUP_C  = `PFBO_SETUP_CYC;
   localparam [23:0] STROBE_C = `PFBO_STROBE_CYC;
   reg  [2:0]  state;
   reg  [2:0]  op;
   reg  [23:0] cnt;
   reg  [63:0] prot_seen;
   wire [15:0] dq_sync;
   pfbo_sync #(.W(16)) u_dq_sync
   (
      .clk_i   (clk_i),
      .rst_n_i (rst_n_i),
      .d_i     (dq_i),
      .q_o     (dq_sync)
   );
   always @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         state          <= S_IDLE;
         op             <= 3'h0;
         cnt            <= 24'h000000;
         prot_seen      <= 64'h0;
         busy_o         <= 1'b0;
         done_o         <= 1'b0;
         rdata_o        <= 16'h0000;
         prot_ok_o      <= 1'b0;
         all_prot_o     <= 1'b0;
         chip_sel_n_o   <= 1'b1;
         chip_sel_hv_o  <= 1'b0;
         out_en_n_o     <= 1'b1;
         out_en_hv_o    <= 1'b0;
         wr_en_n_o      <= 1'b1;
         hard_rst_n_o   <= 1'b0;
         hard_rst_hv_o  <= 1'b0;
         hv_sense_pin_o <= 1'b0;
         byte_word_o    <= 1'b0;
         addr_o         <= 18'h00000;
         dq_o           <= 16'h0000;
         dq_oe_o        <= 1'b0;
         upper_dq_or_lsb_addr_oe_o <= 1'b0;
      end
      else
      begin
         done_o        <= 1'b0;
         hard_rst_n_o  <= 1'b1;
         hard_rst_hv_o <= temp_unprot_i;
         all_prot_o    <= &prot_seen;
         case (state)
            S_IDLE:
            begin
               // idle bus: select high is standby
               chip_sel_n_o <= 1'b1;
               out_en_n_o   <= 1'b1;
               wr_en_n_o    <= 1'b1;
               dq_oe_o      <= 1'b0;
               upper_dq_or_lsb_addr_oe_o <= 1'b0;
               // global unprotect refused until all blocks protected
               if (req_i && !(op_i == `PFBO_OP_UNPROT && !(&prot_seen)))
               begin
                  op          <= op_i;
                  busy_o      <= 1'b1;
                  byte_word_o <= word_mode_i;
                  addr_o      <= addr_i; // block on top six bits
                  // narrow mode drives the extra lsb address
                  upper_dq_or_lsb_addr_oe_o <= !word_mode_i;
                  // narrow data stays on the low byte, dq15 carries wdata_i bit 15
                  dq_o <= word_mode_i ? wdata_i : {wdata_i[15], 7'h00, wdata_i[7:0]};
                  hv_sense_pin_o <= (op_i != `PFBO_OP_READ) && (op_i != `PFBO_OP_WRITE);
                  case (op_i)
                     `PFBO_OP_SIGREAD: addr_o[`PFBO_A1] <= 1'b0;
                     `PFBO_OP_PVERIFY:
                     begin
                        addr_o[`PFBO_A0] <= 1'b0;
                        addr_o[`PFBO_A1] <= 1'b1;
                        addr_o[`PFBO_A6] <= 1'b0;
                     end
                     `PFBO_OP_UVERIFY:
                     begin
                        addr_o[`PFBO_A0] <= 1'b0;
                        addr_o[`PFBO_A1] <= 1'b1;
                        addr_o[`PFBO_A6] <= 1'b1;
                     end
                     `PFBO_OP_UNPROT:
                     begin
                        addr_o[`PFBO_A12] <= 1'b1;
                        addr_o[`PFBO_A15] <= 1'b1;
                     end
                     default: ;
                  endcase
                  cnt   <= SETUP_C;
                  state <= S_SETUP;
               end
            end
            S_SETUP:
            begin
               // address settles before any falling strobe
               case (op)
                  `PFBO_OP_WRITE:
                  begin
                     chip_sel_n_o <= 1'b0;
                     out_en_n_o   <= 1'b1;
                     dq_oe_o      <= 1'b1;
                  end
                  `PFBO_OP_PROTECT:
                  begin
                     chip_sel_n_o <= 1'b0;
                     out_en_hv_o  <= 1'b1;
                  end
                  `PFBO_OP_UNPROT:
                  begin
                     chip_sel_hv_o <= 1'b1;
                     out_en_hv_o   <= 1'b1;
                  end
                  default:
                  begin
                     // read kinds: select low, write high
                     chip_sel_n_o <= 1'b0;
                     out_en_n_o   <= 1'b0;
                     dq_oe_o      <= 1'b0;
                     upper_dq_or_lsb_addr_oe_o <= !byte_word_o;
                  end
               endcase
               if (cnt == 24'h000001)
               begin
                  if (op == `PFBO_OP_WRITE || op == `PFBO_OP_PROTECT || op == `PFBO_OP_UNPROT)
                     wr_en_n_o <= 1'b0;
                  cnt   <= (op == `PFBO_OP_PROTECT) ? PROT_CYC[23:0] :
                           (op == `PFBO_OP_UNPROT) ? UNPROT_CYC[23:0] : STROBE_C;
                  state <= S_STROBE;
               end
               else
                  cnt <= cnt - 24'h000001;
            end
            S_STROBE:
            begin
               if (cnt == 24'h000001)
               begin
                  // write strobe rises first so data latches on it
                  wr_en_n_o <= 1'b1;
                  if (op != `PFBO_OP_WRITE && op != `PFBO_OP_PROTECT && op != `PFBO_OP_UNPROT)
                  begin
                     // ids in low byte; upper zero in narrow mode
                     rdata_o <= byte_word_o ? dq_sync : {8'h00, dq_sync[7:0]};
                     prot_ok_o <= (op == `PFBO_OP_PVERIFY) ? (dq_sync[7:0] == `PFBO_PROT_CODE) :
                                  (op == `PFBO_OP_UVERIFY) ? (dq_sync[7:0] == `PFBO_UNPROT_CODE) :
                                  1'b0;
                     if (op == `PFBO_OP_PVERIFY && dq_sync[7:0] == `PFBO_PROT_CODE)
                        prot_seen[addr_o[17:12]] <= 1'b1;
                     if (op == `PFBO_OP_UVERIFY && dq_sync[7:0] == `PFBO_UNPROT_CODE)
                        prot_seen[addr_o[17:12]] <= 1'b0;
                  end
                  cnt   <= SETUP_C;
                  state <= S_HOLD;
               end
               else
                  cnt <= cnt - 24'h000001;
            end
            S_HOLD:
            begin
               // both strobes high floats device outputs
               out_en_n_o    <= 1'b1;
               out_en_hv_o   <= 1'b0;
               chip_sel_hv_o <= 1'b0;
               if (cnt == 24'h000001)
               begin
                  chip_sel_n_o   <= 1'b1;
                  dq_oe_o        <= 1'b0;
                  hv_sense_pin_o <= 1'b0;
                  state          <= S_DONE;
               end
               else
                  cnt <= cnt - 24'h000001;
            end
            S_DONE:
            begin
               // protected blocks silently ignore writes unless temp_unprot_i is set; host cannot see it
               busy_o <= 1'b0;
               done_o <= 1'b1;
               state  <= S_IDLE;
            end
            default: state <= S_IDLE;
         endcase
      end
   end
endmodule
`default_nettype wire

/* pfbo_host_properties.sv */
`timescale 1ns/1ps
`default_nettype none
`include "pfbo_regs.vh"
module pfbo_host_checker
(
   input wire logic        clk_i,
   input wire logic        rst_n_i,
   input wire logic        req_i,
   input wire logic [2:0]  op_i,
   input wire logic        temp_unprot_i,
   input wire logic        busy_o,
   input wire logic        done_o,
   input wire logic        all_prot_o,
   input wire logic        chip_sel_n_o,
   input wire logic        chip_sel_hv_o,
   input wire logic        out_en_n_o,
   input wire logic        out_en_hv_o,
   input wire logic        wr_en_n_o,
   input wire logic        hard_rst_hv_o,
   input wire logic        hv_sense_pin_o,
   input wire logic [17:0] addr_o,
   input wire logic        dq_oe_o
);
   default clocking dcb @(posedge clk_i);
   endclocking
   default disable iff (!rst_n_i);
   write_gate_a: assert property (!wr_en_n_o && !out_en_hv_o |-> out_en_n_o && !chip_sel_n_o)
      else $error("write strobe without select");
   read_gate_a: assert property (!out_en_n_o |-> !chip_sel_n_o && wr_en_n_o && !dq_oe_o)
      else $error("read strobe conflict");
   write_len_a: assert property ($fell(wr_en_n_o) && !out_en_hv_o |-> !wr_en_n_o [*8])
      else $error("write strobe too short");
   prot_hv_a: assert property ($fell(wr_en_n_o) && out_en_hv_o |-> hv_sense_pin_o)
      else $error("protect pulse without sense level");
   unprot_addr_a: assert property (chip_sel_hv_o && !wr_en_n_o |-> addr_o[12] && addr_o[15] && out_en_hv_o)
      else $error("unprotect pulse bad setup");
   done_pulse_a: assert property (done_o |=> !done_o)
      else $error("done longer than one cycle");
   req_take_a: assert property (req_i && !busy_o && !done_o && op_i != `PFBO_OP_UNPROT && $past(rst_n_i) |=> busy_o)
      else $error("request not taken");
   unprot_refuse_a: assert property (req_i && !busy_o && op_i == `PFBO_OP_UNPROT && !all_prot_o |=> !busy_o)
      else $error("unprotect not refused");
   temp_unprot_a: assert property ($rose(temp_unprot_i) |-> ##[0:3] hard_rst_hv_o)
      else $error("elevated reset missing");
   idle_quiet_a: assert property (!busy_o && !done_o |-> chip_sel_n_o && wr_en_n_o && out_en_n_o)
      else $error("strobes active while idle");
   cover property ($fell(wr_en_n_o) && out_en_hv_o);
   cover property (chip_sel_hv_o && !wr_en_n_o);
   cover property (done_o && hv_sense_pin_o);
endmodule
bind pfbo_host pfbo_host_checker chk_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .req_i(req_i), .op_i(op_i),
   .temp_unprot_i(temp_unprot_i), .busy_o(busy_o), .done_o(done_o), .all_prot_o(all_prot_o),
   .chip_sel_n_o(chip_sel_n_o), .chip_sel_hv_o(chip_sel_hv_o), .out_en_n_o(out_en_n_o),
   .out_en_hv_o(out_en_hv_o), .wr_en_n_o(wr_en_n_o), .hard_rst_hv_o(hard_rst_hv_o),
   .hv_sense_pin_o(hv_sense_pin_o), .addr_o(addr_o), .dq_oe_o(dq_oe_o));
`default_nettype wire

/* pfbo_flash_model.sv */
`timescale 1ns/1ps
`default_nettype none
module pfbo_flash_model
#(
   parameter logic [7:0] MAKER_ID = 8'h5A, // arbitrary value
   parameter logic [7:0] PART_ID  = 8'hA5  // arbitrary value
)
(
   input wire logic        cs_n_i,
   input wire logic        cs_hv_i,
   input wire logic        oe_n_i,
   input wire logic        oe_hv_i,
   input wire logic        we_n_i,
   input wire logic        rst_hv_i,
   input wire logic        hv_i,
   input wire logic        word_i,
   input wire logic [17:0] a_i,
   input wire logic [15:0] d_i,
   output logic [15:0]     q_o
);
   logic [63:0] prot = '0;
   logic [17:0] lat_a;
   logic [17:0] wa = '0;
   logic [15:0] wd = '0;
   logic [15:0] v;
   // one stored word only, enough for read-back
   always @(negedge we_n_i)
      lat_a = a_i;
   always @(posedge we_n_i)
      if (hv_i && oe_hv_i && cs_hv_i && a_i[12] && a_i[15])
         prot = '0;
      else if (hv_i && oe_hv_i && !cs_n_i)
         prot[a_i[17:12]] = 1'b1;
      else if (!cs_n_i && oe_n_i && !hv_i && (!prot[lat_a[17:12]] || rst_hv_i))
      begin
         wa = lat_a;
         wd = d_i;
      end
   always @*
   begin
      if (!hv_i)
         v = (a_i == wa) ? wd : a_i[15:0];
      else if (a_i[1])
         v = {15'h0, prot[a_i[17:12]]};
      else
         v = {word_i ? 8'h00 : a_i[9:2] ^ 8'h3C, a_i[0] ? PART_ID : MAKER_ID};
      // released bus shows the inverse, so a stale value never passes
      q_o = (!cs_n_i && !cs_hv_i && !oe_n_i && !oe_hv_i && we_n_i) ? v : ~v;
   end
endmodule
`default_nettype wire

/* pfbo_host_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "pfbo_regs.vh"
module pfbo_host_tb;
   logic        clk_i = 0, rst_n_i = 0, req_i = 0, word_mode_i = 1, temp_unprot_i = 0;
   logic [2:0]  op_i = 0;
   logic [17:0] addr_i = 0, wa = 0;
   logic [15:0] wdata_i = 0, wd = 0;
   wire  [15:0] rdata_o, dq_o, dev_q, bus;
   wire         busy_o, done_o, ok, allp, cs_n, cs_hv, oe_n, oe_hv, we_n, rst_hv, hv, bw, dq_oe, hrst_n, uoe;
   wire  [17:0] a_o;
   int          bad_count = 0, checked = 0, i, j;
   assign bus = dq_oe ? dq_o : dev_q;
   initial forever #4 clk_i = ~clk_i;
   pfbo_host #(.PROT_CYC(4), .UNPROT_CYC(4)) dut_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .req_i(req_i),
      .op_i(op_i), .addr_i(addr_i), .wdata_i(wdata_i), .word_mode_i(word_mode_i), .temp_unprot_i(temp_unprot_i),
      .busy_o(busy_o), .done_o(done_o), .rdata_o(rdata_o), .prot_ok_o(ok), .all_prot_o(allp),
      .chip_sel_n_o(cs_n), .chip_sel_hv_o(cs_hv), .out_en_n_o(oe_n), .out_en_hv_o(oe_hv), .wr_en_n_o(we_n),
      .hard_rst_n_o(hrst_n), .hard_rst_hv_o(rst_hv), .hv_sense_pin_o(hv), .byte_word_o(bw), .addr_o(a_o),
      .dq_i(bus), .dq_o(dq_o), .dq_oe_o(dq_oe), .upper_dq_or_lsb_addr_oe_o(uoe));
   pfbo_flash_model dev_u (.cs_n_i(cs_n), .cs_hv_i(cs_hv), .oe_n_i(oe_n), .oe_hv_i(oe_hv), .we_n_i(we_n),
      .rst_hv_i(rst_hv), .hv_i(hv), .word_i(bw), .a_i(a_o), .d_i(bus), .q_o(dev_q));
   task end_sim;
      $display("bad_count=%0d checked=%0d", bad_count, checked);
      if (bad_count == 0 && checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task chk(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp)
      begin
         bad_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   function automatic logic [15:0] exp_rd(input logic [17:0] a);
      return (a == wa) ? wd : a[15:0];
   endfunction
   // called at a falling edge; returns at the falling edge showing done, or after a 60-edge wait without done when rf is set
   task run(input logic [2:0] o, input logic [17:0] a, input logic [15:0] d, input logic rf);
      op_i = o;
      addr_i = a;
      wdata_i = d;
      req_i = 1;
      @(negedge clk_i);
      req_i = 0;
      for (j = 0; j < 60 && done_o !== 1'b1; j++)
         @(negedge clk_i);
      if (j == 60 && !rf)
      begin
         bad_count++;
         end_sim;
      end
   endtask
   initial
   begin
      i = $urandom(59184);
      repeat (4) @(negedge clk_i);
      rst_n_i = 1;
      @(negedge clk_i);
      chk({15'h0, hrst_n}, 16'h0001);
      for (i = 0; i < 6; i++)
      begin
         // even passes run in narrow mode, low byte only
         word_mode_i = i[0];
         wa = 18'($urandom);
         wd = 16'($urandom);
         run(`PFBO_OP_WRITE, wa, wd, 0);
         chk(dq_o, i[0] ? wd : {wd[15], 7'h00, wd[7:0]});
         run(`PFBO_OP_READ, wa, 0, 0);
         chk(rdata_o, exp_rd(wa) & (i[0] ? 16'hFFFF : 16'h00FF));
         run(`PFBO_OP_READ, wa ^ 18'h4, 0, 0);
         chk(rdata_o, exp_rd(wa ^ 18'h4) & (i[0] ? 16'hFFFF : 16'h00FF));
      end
      for (i = 0; i < 4; i++)
      begin
         word_mode_i = i[1];
         run(`PFBO_OP_SIGREAD, {17'($urandom), i[0]} & 18'h3FFFD, 0, 0);
         chk(rdata_o, {8'h00, i[0] ? 8'hA5 : 8'h5A});
         chk({15'h0, uoe}, {15'h0, ~i[1]});
      end
      word_mode_i = 1;
      run(`PFBO_OP_UNPROT, 18'h09000, 0, 1);
      chk({15'h0, busy_o}, 16'h0);
      chk(16'(j), 16'h003C);
      run(`PFBO_OP_PROTECT, 18'h05123, 0, 0);
      run(`PFBO_OP_PVERIFY, 18'h05000, 0, 0);
      chk({7'h0, ok, rdata_o[7:0]}, 16'h0101);
      run(`PFBO_OP_PVERIFY, 18'h06000, 0, 0);
      chk({7'h0, ok, rdata_o[7:0]}, 16'h0000);
      run(`PFBO_OP_WRITE, 18'h05123, 16'hBEEF, 0);
      run(`PFBO_OP_READ, 18'h05123, 0, 0);
      chk(rdata_o, exp_rd(18'h05123));
      temp_unprot_i = 1;
      wa = 18'h05123;
      wd = 16'hBEEF;
      run(`PFBO_OP_WRITE, wa, wd, 0);
      run(`PFBO_OP_READ, wa, 0, 0);
      chk(rdata_o, wd);
      temp_unprot_i = 0;
      for (i = 0; i < 64; i++)
      begin
         run(`PFBO_OP_PROTECT, {i[5:0], 12'h0}, 0, 0);
         run(`PFBO_OP_PVERIFY, {i[5:0], 12'h0}, 0, 0);
      end
      chk({15'h0, allp}, 16'h1);
      run(`PFBO_OP_UNPROT, 18'h09000, 0, 0);
      for (i = 0; i < 64; i += 21)
      begin
         run(`PFBO_OP_UVERIFY, {i[5:0], 12'h0}, 0, 0);
         chk({7'h0, ok, rdata_o[7:0]}, 16'h0100);
      end
      // mid-run reset: flash reset pin follows, then a read must still work
      rst_n_i = 0;
      @(negedge clk_i);
      chk({15'h0, hrst_n}, 16'h0000);
      rst_n_i = 1;
      @(negedge clk_i);
      chk({15'h0, hrst_n}, 16'h0001);
      run(`PFBO_OP_READ, wa, 0, 0);
      chk(rdata_o, exp_rd(wa));
      end_sim;
   end
endmodule
`default_nettype wire
